// file: logic/eepc_ctrl.sv
// Module: EEPROM program/erase control with APB register access
module eepc_ctrl
   import eepc_pkg::*;
(
   input  wire logic        pclk,          // Bus clock, 100 MHz
   input  wire logic        presetn,       // Async reset, active low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB direction
   input  wire logic [11:0] paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   input  wire logic        xtal_clk,      // Crystal reference clock (pin)
   input  wire logic        stop_mode,     // Stop mode request (pin)
   input  wire logic        wait_mode,     // Wait mode, no effect
   output logic             pump_on,       // High voltage applied
   output eepc_mode_t       hv_mode,       // Active operation
   output logic [8:0]       hv_addr,       // Array target address
   output logic [7:0]       hv_data,       // Array target data
   output logic             array_off,     // Array powered down
   output logic             array_secure   // Array security active
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  ctrl_reg, acfg_reg, nvcfg_reg, divh_reg, divl_reg;
   logic [7:0]  divhnv_reg, divlnv_reg;
   logic        init_reg;
   logic [1:0]  xs_reg, ss_reg;
   logic        xprev_reg;
   eepc_latch_t lat_reg;
   logic        nonarr_wr_reg;
   logic [10:0] div_cnt_reg;
   logic        tick;
   logic [7:0]  tmr_reg;
   logic        wr_acc, rd_acc, arr_hit, prot_hit, pgm_set, tmr_done;
   logic [7:0]  wb, ctrl_next;
   logic [10:0] divisor;
   logic        secd;

   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & penable & ~pwrite;
   assign wb      = pwdata[7:0];
   assign arr_hit = paddr >= EEPC_OFS_ARRAY &&
                    paddr < EEPC_OFS_ARRAY + 12'h200;
   assign divisor = {divh_reg[2:0], divl_reg};
   assign secd    = divh_reg[EEPC_B_SECD];
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // Protection of the latched target: block bit, or any block bit for bulk
   always_comb begin
      prot_hit = acfg_reg[lat_reg.addr[EEPC_BLK_MSB:EEPC_BLK_LSB]];
      if (ctrl_reg[EEPC_B_ERSH:EEPC_B_ERSL] == 2'b11)
         prot_hit = |acfg_reg[3:0];
   end

   // Nonvolatile copies load the volatile registers after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_reg <= 1'b1;
      end else begin
         init_reg <= 1'b0;
      end
   end

   // Reference clock and stop request synchronisers, with reference edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xs_reg    <= 2'b00;
         ss_reg    <= 2'b00;
         xprev_reg <= 1'b0;
      end else begin
         xs_reg    <= {xs_reg[0], xtal_clk};
         ss_reg    <= {ss_reg[0], stop_mode};
         xprev_reg <= xs_reg[1];
      end
   end

   // Divide selected reference by the divisor to a 35us tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_reg <= 11'h000;
      end else begin
         if (tick) begin
            div_cnt_reg <= 11'h000;
         end else if (nvcfg_reg[EEPC_B_CLKSEL] ? (xs_reg[1] & ~xprev_reg)
                                               : 1'b1) begin
            div_cnt_reg <= div_cnt_reg + 11'h001;
         end
      end
   end
   assign tick = (divisor != 11'h000) && (div_cnt_reg + 11'h001 >= divisor)
                 && (nvcfg_reg[EEPC_B_CLKSEL] ? (xs_reg[1] & ~xprev_reg)
                                              : 1'b1);

   // Program/erase timer counts ticks while voltage is applied
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_reg <= 8'h00;
      end else if (!pump_on) begin
         if (!ctrl_reg[EEPC_B_PGM])
            tmr_reg <= 8'h00;
      end else if (tick && tmr_reg != EEPC_TICKS_AUTO) begin
         tmr_reg <= tmr_reg + 8'h01;
      end
   end
   assign tmr_done = pump_on && tick && tmr_reg + 8'h01 == EEPC_TICKS_AUTO;

   // Enable may be set only when a valid array write was latched
   assign pgm_set = wb[EEPC_B_PGM] & ctrl_reg[EEPC_B_LATCH] &
                    lat_reg.valid & ~nonarr_wr_reg;

   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_acc && paddr == EEPC_OFS_CTRL) begin
         ctrl_next = wb;
         ctrl_next[1] = 1'b0;
         ctrl_next[EEPC_B_PGM] = pgm_set | (ctrl_reg[EEPC_B_PGM] &
                                 wb[EEPC_B_PGM]);
         if (ctrl_reg[EEPC_B_PGM])
            ctrl_next[EEPC_B_LATCH] = 1'b1;
         if (ctrl_reg[EEPC_B_PGM]) begin
            ctrl_next[EEPC_B_ERSH] = ctrl_reg[EEPC_B_ERSH];
            ctrl_next[EEPC_B_ERSL] = ctrl_reg[EEPC_B_ERSL];
         end
      end
      if (tmr_done && ctrl_reg[EEPC_B_AUTO])
         ctrl_next[EEPC_B_PGM] = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= EEPC_CTRL_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Latch capture of array writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat_reg       <= '0;
         nonarr_wr_reg <= 1'b0;
      end else if (!ctrl_reg[EEPC_B_LATCH]) begin
         lat_reg.valid <= 1'b0;
         if (wr_acc)
            nonarr_wr_reg <= ~arr_hit;
      end else if (wr_acc && arr_hit && !ctrl_reg[EEPC_B_PGM]) begin
         lat_reg <= '{addr: paddr[EEPC_ARR_AW-1:0], data: wb, valid: 1'b1};
         nonarr_wr_reg <= 1'b0;
      end
   end

   // Nonvolatile bytes (stored here) and volatile config
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nvcfg_reg  <= EEPC_NVCFG_DEF;
         divhnv_reg <= EEPC_DIVHNV_DEF;
         divlnv_reg <= EEPC_DIVLNV_DEF;
         acfg_reg   <= 8'h00;
      end else begin
         if (init_reg || (rd_acc && paddr == EEPC_OFS_NVCFG))
            acfg_reg <= nvcfg_reg;
         if (wr_acc && paddr == EEPC_OFS_NVCFG)
            nvcfg_reg <= wb;
         if (wr_acc && secd && paddr == EEPC_OFS_DIVHNV)
            divhnv_reg <= wb;
         if (wr_acc && secd && paddr == EEPC_OFS_DIVLNV)
            divlnv_reg <= wb;
      end
   end

   // Volatile divider: loaded from the nonvolatile copies after reset, then software writes with SECD set and latch clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divh_reg <= 8'h00;
         divl_reg <= 8'h00;
      end else if (init_reg) begin
         divh_reg <= divhnv_reg;
         divl_reg <= divlnv_reg;
      end else if (wr_acc && !ctrl_reg[EEPC_B_LATCH] && secd) begin
         if (paddr == EEPC_OFS_DIVH)
            divh_reg <= {wb[7], 4'h0, wb[2:0]};
         if (paddr == EEPC_OFS_DIVL)
            divl_reg <= wb;
      end
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (arr_hit && ctrl_reg[EEPC_B_LATCH] && lat_reg.valid)
            prdata[7:0] <= lat_reg.data;
         else begin
            unique case (paddr)
               EEPC_OFS_CTRL:   prdata[7:0] <= ctrl_reg;
               EEPC_OFS_NVCFG:  prdata[7:0] <= nvcfg_reg;
               EEPC_OFS_ACFG:   prdata[7:0] <= acfg_reg;
               EEPC_OFS_DIVH:   prdata[7:0] <= divh_reg;
               EEPC_OFS_DIVL:   prdata[7:0] <= divl_reg;
               EEPC_OFS_DIVHNV: prdata[7:0] <= divhnv_reg;
               EEPC_OFS_DIVLNV: prdata[7:0] <= divlnv_reg;
               EEPC_OFS_STATUS: prdata[7:0] <= {7'h00, pump_on};
               default:         prdata[7:0] <= 8'h00;
            endcase
         end
      end
   end

   // High voltage gate
   assign pump_on = ctrl_reg[EEPC_B_PGM] & ctrl_reg[EEPC_B_LATCH] &
                    lat_reg.valid & ~prot_hit & ~ss_reg[1] &
                    ~ctrl_reg[EEPC_B_PDOWN];
   assign hv_mode      = eepc_mode_t'(ctrl_reg[EEPC_B_ERSH:EEPC_B_ERSL]);
   assign hv_addr      = lat_reg.addr;
   assign hv_data      = lat_reg.data;
   assign array_off    = ctrl_reg[EEPC_B_PDOWN];
   assign array_secure = ~acfg_reg[EEPC_CFG_SEC];
endmodule : eepc_ctrl

// file: common/eepc_pkg.sv
// Package: register map, field layout, reset values and timing for EEPROM control
package eepc_pkg;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] EEPC_OFS_CTRL    = 12'h000;
   localparam logic [11:0] EEPC_OFS_NVCFG   = 12'h004;
   localparam logic [11:0] EEPC_OFS_ACFG    = 12'h008;
   localparam logic [11:0] EEPC_OFS_DIVH    = 12'h00c;
   localparam logic [11:0] EEPC_OFS_DIVL    = 12'h010;
   localparam logic [11:0] EEPC_OFS_DIVHNV  = 12'h014;
   localparam logic [11:0] EEPC_OFS_DIVLNV  = 12'h018;
   localparam logic [11:0] EEPC_OFS_STATUS  = 12'h01c;
   localparam logic [11:0] EEPC_OFS_ARRAY   = 12'h800;
   localparam int          EEPC_ARR_AW      = 9;
   localparam int          EEPC_BLK_MSB     = 8;
   localparam int          EEPC_BLK_LSB     = 7;
   // Control register fields, then DIVH and NVCFG bits and reset values
   localparam int          EEPC_B_SPARE     = 7;
   localparam int          EEPC_B_PDOWN     = 6;
   localparam int          EEPC_B_ERSH      = 5;
   localparam int          EEPC_B_ERSL      = 4;
   localparam int          EEPC_B_LATCH     = 3;
   localparam int          EEPC_B_AUTO      = 2;
   localparam int          EEPC_B_PGM       = 0;
   localparam int          EEPC_B_SECD      = 7;
   localparam int          EEPC_B_CLKSEL    = 4;
   localparam logic [7:0]  EEPC_CTRL_RST    = 8'h00;
   localparam logic [7:0]  EEPC_NVCFG_DEF   = 8'h70;
   localparam logic [7:0]  EEPC_DIVHNV_DEF  = 8'h80;
   localparam logic [7:0]  EEPC_DIVLNV_DEF  = 8'hac;
   localparam int          EEPC_CFG_SEC     = 4;
   // Program/erase timer length in timebase ticks, and the timebase period
   localparam logic [7:0]  EEPC_TICKS_AUTO  = 8'h80;
   localparam real         EEPC_TB_US       = 35.0;
   localparam int          EEPC_CLK_MHZ     = 100;
   localparam int          EEPC_TB_CYC      = int'(EEPC_TB_US) * EEPC_CLK_MHZ;

   typedef enum logic [1:0] {
      EEPC_BYTE_PGM, EEPC_BYTE_ERASE, EEPC_BLOCK_ERASE, EEPC_BULK_ERASE
   } eepc_mode_t;

   typedef struct packed {
      logic [8:0]  addr;
      logic [7:0]  data;
      logic        valid;
   } eepc_latch_t;
endpackage : eepc_pkg

// file: bench/eepc_ctrl_chk.sv
// Assertion checker for the EEPROM program/erase control ports
module eepc_ctrl_chk
   import eepc_pkg::*;
(
   input logic        pclk,     // Bus clock
   input logic        presetn,  // Async reset
   input logic        psel,     // APB select
   input logic        penable,  // APB enable
   input logic        pwrite,   // APB direction
   input logic [11:0] paddr,    // APB address
   input logic [31:0] pwdata,   // APB write data
   input logic [31:0] prdata,   // APB read data
   input logic        pready,   // APB ready
   input logic        pslverr,  // APB error
   input logic        stop_mode, // Stop request
   input logic        pump_on,  // High voltage
   input eepc_mode_t  hv_mode,  // Active mode
   input logic [8:0]  hv_addr,  // Target address
   input logic        array_off // Power down
);
   timeunit 1ns;
   timeprecision 1ps;
   wire wr_c = psel && penable && pwrite && (paddr == EEPC_OFS_CTRL);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_stop;
      stop_mode [*3];
   endsequence
   property p_stop; s_stop |-> !pump_on; endproperty
   a_stop: assert property (p_stop) else $error("pump on in stop");
   property p_rdy; pready && !pslverr; endproperty
   a_rdy: assert property (p_rdy) else $error("bad bus answer");
   property p_prd; prdata[31:8] == 24'h0; endproperty
   a_prd: assert property (p_prd) else $error("read upper bits");
   property p_clr; wr_c && !pwdata[EEPC_B_PGM] |=> !pump_on; endproperty
   a_clr: assert property (p_clr) else $error("pump stays on");
   property p_rise;
      $rose(pump_on) |-> $past(wr_c && pwdata[EEPC_B_PGM])
         || $past(stop_mode, 2) || $past(stop_mode, 3) || $past(stop_mode, 4);
   endproperty
   a_rise: assert property (p_rise) else $error("pump on uncaused");
   property p_hold;
      pump_on && $past(pump_on) |-> $stable(hv_addr) && $stable(hv_mode);
   endproperty
   a_hold: assert property (p_hold) else $error("target moved");
   property p_off;
      wr_c |=> array_off == $past(pwdata[EEPC_B_PDOWN]);
   endproperty
   a_off: assert property (p_off) else $error("power down bit");
   property p_mode;
      wr_c && !pump_on && !stop_mode && !pwdata[EEPC_B_PGM]
         |=> hv_mode == $past(pwdata[5:4]);
   endproperty
   a_mode: assert property (p_mode) else $error("mode not taken");
   property p_rst;
      !$past(presetn) |-> !pump_on && !array_off && hv_mode == EEPC_BYTE_PGM;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
endmodule : eepc_ctrl_chk

bind eepc_ctrl eepc_ctrl_chk eepc_ctrl_chk_i (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .stop_mode, .pump_on, .hv_mode, .hv_addr, .array_off);

// file: bench/eepc_ctrl_tb_top.sv
// Testbench for the EEPROM program/erase control block
module eepc_ctrl_tb_top;
   import eepc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, xtal_clk;
   logic        stop_mode, wait_mode, pready, pslverr, pump_on;
   logic        array_off, array_secure;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [8:0]  hv_addr;
   logic [7:0]  hv_data;
   eepc_mode_t  hv_mode;
   int          mismatches, n_checks, n, m, b;
   eepc_ctrl eepc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .xtal_clk, .stop_mode, .wait_mode,
      .pump_on, .hv_mode, .hv_addr, .hv_data, .array_off, .array_secure);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) xtal_clk <= ~xtal_clk;
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   task ck(input logic [8:0] g, input logic [8:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask : ck
   task bus(input logic [11:0] a, input logic w, input logic [7:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         end_sim();
      end
   endtask : bus
   task wr(input logic [11:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask : wr
   task arw(input logic [8:0] a, input logic [7:0] d);
      bus(EEPC_OFS_ARRAY | {3'h0, a}, 1'b1, d);
   endtask : arw
   task rdc(input logic [11:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      ck({1'b0, prdata[7:0]}, {1'b0, e});
   endtask : rdc
   task pump(input logic e);
      @(posedge pclk);
      ck(9'(pump_on), 9'(e));
   endtask : pump
   initial begin
      {presetn, psel, penable, pwrite, xtal_clk, stop_mode, wait_mode} = '0;
      paddr = '0;
      pwdata = '0;
      mismatches = 0;
      n_checks = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rdc(EEPC_OFS_CTRL, 8'h00);
      rdc(EEPC_OFS_ACFG, EEPC_NVCFG_DEF);
      rdc(EEPC_OFS_DIVH, EEPC_DIVHNV_DEF);
      rdc(EEPC_OFS_DIVL, EEPC_DIVLNV_DEF);
      ck(9'(array_secure), 9'h0);
      wr(EEPC_OFS_DIVL, 8'h02);
      rdc(EEPC_OFS_DIVL, 8'h02);
      wr(EEPC_OFS_CTRL, 8'h08);
      wr(EEPC_OFS_DIVL, 8'h55);
      rdc(EEPC_OFS_DIVL, 8'h02);
      arw(9'h0a3, 8'h5a);
      arw(9'h145, 8'h3c);
      rdc(EEPC_OFS_ARRAY | 12'h1ff, 8'h3c);
      ck(hv_addr, 9'h145);
      ck({1'b0, hv_data}, 9'h03c);
      for (m = 0; m < 4; m++) begin
         wr(EEPC_OFS_CTRL, 8'(8'h08 | (m << 4)));
         arw(9'h145, 8'ha5);
         wait_mode <= (m == 0);
         wr(EEPC_OFS_CTRL, 8'(8'h09 | (m << 4)));
         pump(1'b1);
         ck(9'(hv_mode), 9'(m));
         if (m == 0) begin
            wr(EEPC_OFS_CTRL, 8'h01);
            rdc(EEPC_OFS_CTRL, 8'h09);
            stop_mode <= 1'b1;
            repeat (5) @(posedge pclk);
            pump(1'b0);
            rdc(EEPC_OFS_CTRL, 8'h09);
            stop_mode <= 1'b0;
            repeat (5) @(posedge pclk);
            pump(1'b1);
         end
         wr(EEPC_OFS_CTRL, 8'(m << 4));
         rdc(EEPC_OFS_CTRL, 8'(8'h08 | (m << 4)));
         pump(1'b0);
      end
      wr(EEPC_OFS_CTRL, 8'h00);
      for (b = 0; b < 4; b++) begin
         wr(EEPC_OFS_NVCFG, 8'(8'h70 | (1 << b)));
         rdc(EEPC_OFS_NVCFG, 8'(8'h70 | (1 << b)));
         wr(EEPC_OFS_CTRL, 8'h08);
         arw(9'(b * 128 + 7), 8'h11);
         wr(EEPC_OFS_CTRL, 8'h09);
         pump(1'b0);
         wr(EEPC_OFS_CTRL, 8'h08);
         arw(9'((b ^ 1) * 128 + 7), 8'h11);
         wr(EEPC_OFS_CTRL, 8'h09);
         pump(1'b1);
         wr(EEPC_OFS_CTRL, 8'h08);
         wr(EEPC_OFS_CTRL, 8'h00);
      end
      // Auto run on the bus clock, then on the crystal clock
      for (b = 0; b < 2; b++) begin
         wr(EEPC_OFS_NVCFG, 8'(8'h60 | (b << 4)));
         rdc(EEPC_OFS_NVCFG, 8'(8'h60 | (b << 4)));
         wr(EEPC_OFS_CTRL, 8'h0c);
         ck(9'(array_secure), 9'(1 - b));
         arw(9'h145, 8'h77);
         wr(EEPC_OFS_CTRL, 8'h0d);
         n = 0;
         do begin
            bus(EEPC_OFS_CTRL, 1'b0, 8'h00);
            n++;
         end while (prdata[0] !== 1'b0 && n < 400);
         ck(9'(prdata[0]), 9'h0);
         if (prdata[0] !== 1'b0) end_sim();
         m = (int'(EEPC_TICKS_AUTO) - 1) * 2 * (b + 1);
         ck(9'(3 * n > m), 9'h1);
         wr(EEPC_OFS_CTRL, 8'h00);
      end
      wr(12'h100, 8'hff);
      wr(EEPC_OFS_CTRL, 8'h01);
      rdc(EEPC_OFS_CTRL, 8'h00);
      wr(EEPC_OFS_CTRL, 8'h40);
      @(posedge pclk);
      ck(9'(array_off), 9'h1);
      wr(EEPC_OFS_CTRL, 8'h00);
      wr(EEPC_OFS_DIVH, 8'h00);
      wr(EEPC_OFS_DIVL, 8'h77);
      rdc(EEPC_OFS_DIVL, 8'h02);
      wr(EEPC_OFS_DIVH, 8'h80);
      rdc(EEPC_OFS_DIVH, 8'h00);
      wr(EEPC_OFS_DIVHNV, 8'h00);
      rdc(EEPC_OFS_DIVHNV, EEPC_DIVHNV_DEF);
      end_sim();
   end
endmodule : eepc_ctrl_tb_top
